/* File: clkgen_regs.svh */
// constants of the clock generation control block
// assumes inclusion by its bare name from the package, the main module, the checker and the bench
`ifndef CLKGEN_REGS_SVH
`define CLKGEN_REGS_SVH
// ------------------------------------------------------------
// mode word field positions
// ------------------------------------------------------------
`define MODE_REF_SRC_BIT 0
`define MODE_DIV_BYPASS_BIT 1
`define MODE_PRE_BYPASS_BIT 2
`define MODE_PRE_RATIO_BIT 3
`define MODE_PIN_FUNC_BIT 4
`define MODE_TAP_DIS_BIT 5
`define CFG_WORD_W 9
// ------------------------------------------------------------
// configuration store addresses and reset values
// ------------------------------------------------------------
`define CFG_ADDR_MODE 1'h0
`define CFG_ADDR_DIV 1'h1
`define MODE_RESET 9'h000
`define DIV_RESET 9'h000
`define DIVISOR_OFFSET 10'h002
`define CMD_W 2
`endif

/* File: clkgen_pkg.sv */
// types of the clock generation control block
// assumes clkgen_regs.svh is on the include path
`include "clkgen_regs.svh"
package clkgen_pkg;
  // decoded mode word
  typedef struct packed {
    logic tap_disable_bit;
    logic pin_function_bit;
    logic prescale_ratio;
    logic prescaler_bypass;
    logic divider_bypass;
    logic ref_source;
  } mode_s;
  // serial programming command
  typedef enum logic [`CMD_W-1:0] {
    CMD_NONE = 2'h0,
    CMD_LOAD_MODE = 2'h1,
    CMD_LOAD_DIV = 2'h2,
    CMD_WRITE = 2'h3
  } cmd_e;
  // power-down sequencer states, one-hot
  typedef enum logic [3:0] {
    PD_RUN = 4'h1,
    PD_GATE_MAIN = 4'h2,
    PD_GATE_TAP = 4'h4,
    PD_OFF = 4'h8
  } pd_state_e;
endpackage

/* File: cfg_store.sv */
// nonvolatile configuration store, two 9-bit words
// assumes the main module writes it only in programming mode
`timescale 1ns/100ps
`default_nettype none
module cfg_store #(
  parameter int WIDTH = 9
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem_r [0:1];
  // no reset: contents survive power cycles
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
    rd_data <= mem_r[rd_addr];
  end
endmodule
`default_nettype wire

/* File: ref_select_prescale_divider_ctrl.sv */
// clock generation control: reference select, prescaler, divider,
// synchronous output gating, power-down sequencing, mode word decode
// assumes clk is the master reference; ref clocks and pins arrive async
// Function
// R1: gate high lets main output toggle freely
// R2: gate low holds output low, no short pulse; code keeps it high if gated before the last high count, divisor 4 or more
// R3: gated off keeps oscillator, resets divider
// R4: gated off still drives tap if enabled
// R5: first transition one to two prescaled periods
// R6: pin low powers down in sequence; code stalls in PD_GATE_MAIN when the output is left high, divisor 4 or more
// R7: after power-down both outputs float
// R8: pin function clear lets pin select reference
// R9: tap follows reference mux, ignores gate
// R10: tap disable bit keeps tap off
// R11: settings apply only at operating power-up
// R12: config is mode word plus divider word
// R13: programmer writes top three bits zero
// R14: source bit selects external when one
// R15: divider bypass routes master to output
// R16: bypass with internal also skips prescaler
// R17: prescaler bypass bit skips prescaler
// R18: ratio bit zero four, one two
// R19: external reference skips the prescaler
// R20: programming mode loads words serially
// R21: divisor is code plus two
// R22: power-down resets divider, floats when low
// R23: async inputs pass two flip-flops
`timescale 1ns/100ps
`default_nettype none
`include "clkgen_regs.svh"
module ref_select_prescale_divider_ctrl #(
  parameter int CFG_W = `CFG_WORD_W,
  parameter int SYNC_STAGES = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic internal_osc,
  input wire logic ext_ref_pin,
  input wire logic output_gate_pin,
  input wire logic powerdown_or_refsel_pin,
  input wire logic program_mode,
  input wire logic prog_data_in,
  input wire logic prog_strobe,
  input wire logic [`CMD_W-1:0] prog_cmd,
  output logic main_out,
  output logic main_out_oe,
  output logic reference_tap_pin,
  output logic reference_tap_oe,
  output logic osc_enable
);
  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  // the field positions and the divisor offset assume 9-bit words
  if (CFG_W != 9) begin : g_bad_width
    $error("configuration words must be 9 bits");
  end
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("at least two synchroniser stages needed");
  end

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  // reference clocks are sampled here too, so the block sees them only as
  // levels; every later edge detect works on the synced copies
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync_out;
  assign async_in = {prog_strobe, prog_data_in, program_mode, ext_ref_pin,
                     internal_osc, powerdown_or_refsel_pin, output_gate_pin};
  // each async input passes a chain of flops
  // chains clear low; no output acts on them until the words are loaded
  genvar gi;
  for (gi = 0; gi < NSYNC; gi++) begin : g_sync
    logic [SYNC_STAGES-1:0] chain_r;
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        chain_r <= '0;
      end else begin
        chain_r <= {chain_r[SYNC_STAGES-2:0], async_in[gi]}; // R23
      end
    end
    assign sync_out[gi] = chain_r[SYNC_STAGES-1];
  end
  // synchronised inputs by name
  logic gate_s, pdsel_s, int_s, ext_s, prog_s, pdata_s, pstb_s;
  assign gate_s = sync_out[0];
  assign pdsel_s = sync_out[1];
  assign int_s = sync_out[2];
  assign ext_s = sync_out[3];
  assign prog_s = sync_out[4];
  assign pdata_s = sync_out[5];
  assign pstb_s = sync_out[6];

  // ------------------------------------------------------------
  // serial programming and configuration store
  // ------------------------------------------------------------
  logic pstb_d_r;
  logic [CFG_W-1:0] shift_r;
  logic [CFG_W-1:0] mode_stage_r;
  logic [CFG_W-1:0] div_stage_r;
  logic [1:0] wr_phase_r;
  logic pstb_rise;
  clkgen_pkg::cmd_e cmd_w;
  assign pstb_rise = pstb_s && !pstb_d_r;
  assign cmd_w = clkgen_pkg::cmd_e'(prog_cmd);
  // the command lines are on this clock and are read only at the synced
  // strobe rise, so they must hold while the strobe is high
  // shift serial bits in msb first on each strobe with no command
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pstb_d_r <= 1'b0;
      shift_r <= '0;
      mode_stage_r <= `MODE_RESET;
      div_stage_r <= `DIV_RESET;
    end else begin
      pstb_d_r <= pstb_s;
      if (prog_s && pstb_rise) begin
        unique case (cmd_w)
          clkgen_pkg::CMD_NONE: shift_r <= {shift_r[CFG_W-2:0], pdata_s}; // R20
          clkgen_pkg::CMD_LOAD_MODE: mode_stage_r <= {3'h0, shift_r[5:0]}; // R13
          clkgen_pkg::CMD_LOAD_DIV: div_stage_r <= shift_r; // R12
          clkgen_pkg::CMD_WRITE: ;
        endcase
      end
    end
  end
  // write command commits both words, one per cycle
  logic do_write;
  assign do_write = prog_s && pstb_rise && (cmd_w == clkgen_pkg::CMD_WRITE);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_phase_r <= 2'h0;
    end else if (do_write) begin
      wr_phase_r <= 2'h1;
    end else if (wr_phase_r == 2'h1) begin
      wr_phase_r <= 2'h2;
    end else begin
      wr_phase_r <= 2'h0;
    end
  end
  logic st_wr_en, st_wr_addr, st_rd_addr;
  logic [CFG_W-1:0] st_wr_data, st_rd_data;
  // store write port: mode word in phase one, divider word in phase two
  assign st_wr_en = (wr_phase_r != 2'h0); // R20
  assign st_wr_addr = (wr_phase_r == 2'h1) ? `CFG_ADDR_MODE : `CFG_ADDR_DIV;
  assign st_wr_data = (wr_phase_r == 2'h1) ? mode_stage_r : div_stage_r;
  cfg_store #(.WIDTH(CFG_W)) u_store (
    .clk(clk),
    .wr_en(st_wr_en),
    .wr_addr(st_wr_addr),
    .wr_data(st_wr_data),
    .rd_addr(st_rd_addr),
    .rd_data(st_rd_data)
  );

  // ------------------------------------------------------------
  // power-up load of working registers
  // ------------------------------------------------------------
  logic [2:0] load_step_r;
  logic loaded_r;
  logic [CFG_W-1:0] mode_select_word_r;
  logic [CFG_W-1:0] divisor_word_r;
  // read data lag the address by one cycle: step one sees the mode word,
  // step two the divider word
  assign st_rd_addr = load_step_r[0] ? `CFG_ADDR_DIV : `CFG_ADDR_MODE;
  // words are latched once after reset, never on the fly
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      load_step_r <= 3'h0;
      loaded_r <= 1'b0;
      mode_select_word_r <= `MODE_RESET;
      divisor_word_r <= `DIV_RESET;
    end else if (!loaded_r && !prog_s) begin
      load_step_r <= load_step_r + 3'h1;
      if (load_step_r == 3'h1) begin
        mode_select_word_r <= st_rd_data; // R11
      end
      if (load_step_r == 3'h2) begin
        divisor_word_r <= st_rd_data; // R11
        loaded_r <= 1'b1;
      end
    end
  end
  clkgen_pkg::mode_s mode;
  assign mode = '{
    tap_disable_bit: mode_select_word_r[`MODE_TAP_DIS_BIT],
    pin_function_bit: mode_select_word_r[`MODE_PIN_FUNC_BIT],
    prescale_ratio: mode_select_word_r[`MODE_PRE_RATIO_BIT],
    prescaler_bypass: mode_select_word_r[`MODE_PRE_BYPASS_BIT],
    divider_bypass: mode_select_word_r[`MODE_DIV_BYPASS_BIT],
    ref_source: mode_select_word_r[`MODE_REF_SRC_BIT]
  };
  logic running;
  assign running = loaded_r && !prog_s;

  // ------------------------------------------------------------
  // reference select and prescaler
  // ------------------------------------------------------------
  logic use_ext, pd_request;
  assign use_ext = mode.pin_function_bit ? mode.ref_source : !pdsel_s; // R8 R14
  assign pd_request = mode.pin_function_bit && !pdsel_s; // R6
  logic ref_clk, ref_d_r, ref_rise;
  // the selected reference feeds both the prescaler and the tap
  assign ref_clk = use_ext ? ext_s : int_s; // R9
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ref_d_r <= 1'b0;
    end else begin
      ref_d_r <= ref_clk;
    end
  end
  assign ref_rise = ref_clk && !ref_d_r;
  // prescaler only on the internal path without divider bypass
  logic pre_active;
  logic [1:0] pre_cnt_r;
  logic [1:0] pre_last;
  assign pre_active = !use_ext && !mode.divider_bypass && !mode.prescaler_bypass; // R16 R17 R19
  assign pre_last = mode.prescale_ratio ? 2'h1 : 2'h3; // R18
  // the count wraps at or above the last value, so it can never stick
  // beyond the ratio in use
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pre_cnt_r <= 2'h0;
    end else if (ref_rise) begin
      pre_cnt_r <= (pre_cnt_r >= pre_last) ? 2'h0 : pre_cnt_r + 2'h1;
    end
  end
  logic mclk_tick;
  assign mclk_tick = ref_rise && (!pre_active || pre_cnt_r >= pre_last);

  // ------------------------------------------------------------
  // power-down sequencer
  // ------------------------------------------------------------
  clkgen_pkg::pd_state_e pd_r, pd_nxt;
  logic main_gate_off;
  logic en_r;
  assign main_gate_off = !gate_s || (pd_r != clkgen_pkg::PD_RUN);
  // one-hot state decodes shared by the output drivers
  function automatic logic main_released(input clkgen_pkg::pd_state_e s);
    return (s == clkgen_pkg::PD_GATE_TAP) || (s == clkgen_pkg::PD_OFF);
  endfunction
  function automatic logic tap_following(input clkgen_pkg::pd_state_e s);
    return (s == clkgen_pkg::PD_RUN) || (s == clkgen_pkg::PD_GATE_MAIN);
  endfunction
  // the main output is released only once its counter is held and the
  // line is low; with the gate still open a late master tick could start
  // one more pulse after the drive enable had dropped
  always_comb begin
    pd_nxt = pd_r;
    unique case (pd_r)
      clkgen_pkg::PD_RUN: if (pd_request && running) pd_nxt = clkgen_pkg::PD_GATE_MAIN; // R6
      clkgen_pkg::PD_GATE_MAIN: if (!main_out && !en_r) pd_nxt = clkgen_pkg::PD_GATE_TAP; // R22
      clkgen_pkg::PD_GATE_TAP: if (!reference_tap_pin) pd_nxt = clkgen_pkg::PD_OFF;
      clkgen_pkg::PD_OFF: if (!pd_request) pd_nxt = clkgen_pkg::PD_RUN;
      default: pd_nxt = clkgen_pkg::PD_RUN;
    endcase
  end
  // sequencer returns to run only from off, once the pin is released
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pd_r <= clkgen_pkg::PD_RUN;
    end else begin
      pd_r <= pd_nxt;
    end
  end

  // ------------------------------------------------------------
  // programmable divider and synchronous gate
  // ------------------------------------------------------------
  localparam int DCW = CFG_W + 1;
  logic [DCW-1:0] divisor;
  logic [DCW-1:0] div_cnt_r;
  logic [DCW-1:0] half_div;
  assign divisor = {1'b0, divisor_word_r} + `DIVISOR_OFFSET; // R21
  // high for the lower half of the count; an odd divisor gives its
  // extra tick to the low phase
  assign half_div = divisor >> 1;
  // gate sampled on master clock ticks, so it only changes on a tick
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      en_r <= 1'b0;
    end else if (mclk_tick) begin
      en_r <= !main_gate_off && running;
    end
  end
  // counter held in reset while gated, fixed phase on release
  always_ff @(posedge clk) begin
    if (!rst_n || !en_r) begin
      div_cnt_r <= '0; // R3 R22
    end else if (mclk_tick) begin
      div_cnt_r <= (div_cnt_r >= divisor - 10'h001) ? '0 : div_cnt_r + 10'h001;
    end
  end
  logic div_level, bypass_level, main_level;
  assign div_level = (div_cnt_r < half_div);
  assign bypass_level = ref_clk; // R15 R16
  assign main_level = mode.divider_bypass ? bypass_level : div_level;
  // output goes low only at its own falling edge, rises only when enabled
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      main_out <= 1'b0;
    end else if (!en_r) begin
      main_out <= main_out && main_level; // R2
    end else begin
      main_out <= main_level; // R1 R5
    end
  end
  // main drive enable, dropped once the sequencer has released the line
  logic main_oe_nxt;
  assign main_oe_nxt = running && !main_released(pd_r); // R7 R22
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      main_out_oe <= 1'b0;
    end else begin
      main_out_oe <= main_oe_nxt; // R7
    end
  end

  // ------------------------------------------------------------
  // reference tap and oscillator enable
  // ------------------------------------------------------------
  logic tap_on;
  assign tap_on = running && !mode.tap_disable_bit; // R10
  // tap ignores output gate; drops low cleanly during power-down
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reference_tap_pin <= 1'b0;
      reference_tap_oe <= 1'b0;
      osc_enable <= 1'b1;
    end else begin
      // past the main stage the tap may only fall, never start a pulse
      if (tap_following(pd_r)) begin
        reference_tap_pin <= tap_on && ref_clk; // R4 R9
      end else begin
        reference_tap_pin <= reference_tap_pin && ref_clk;
      end
      reference_tap_oe <= tap_on && (pd_r != clkgen_pkg::PD_OFF); // R7 R10
      osc_enable <= (pd_r != clkgen_pkg::PD_OFF); // R3 R6
    end
  end
endmodule
`default_nettype wire

/* File: ref_ctrl_checker.sv */
// port-level assertions for the clock generation control block
// assumes binding to ref_select_prescale_divider_ctrl, one clock domain
`timescale 1ns/100ps
`default_nettype none
`include "clkgen_regs.svh"
module ref_ctrl_checker #(
  parameter int CFG_W = 9,
  parameter int SYNC_STAGES = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic internal_osc,
  input wire logic ext_ref_pin,
  input wire logic output_gate_pin,
  input wire logic powerdown_or_refsel_pin,
  input wire logic program_mode,
  input wire logic prog_data_in,
  input wire logic prog_strobe,
  input wire logic [`CMD_W-1:0] prog_cmd,
  input wire logic main_out,
  input wire logic main_out_oe,
  input wire logic reference_tap_pin,
  input wire logic reference_tap_oe,
  input wire logic osc_enable
);
  localparam int GRACE = 48; // longest master tick plus sync slack
  logic [7:0] low_cnt_r;
  // consecutive cycles with the gate low, saturating
  always_ff @(posedge clk) begin
    if (!rst_n || output_gate_pin) begin
      low_cnt_r <= 8'h00;
    end else if (low_cnt_r != 8'hff) begin
      low_cnt_r <= low_cnt_r + 8'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_main_float; $fell(main_out_oe); endsequence
  sequence s_tap_float; $fell(reference_tap_oe); endsequence
  sequence s_osc_stop; $fell(osc_enable); endsequence
  // power-down ordering, glitch-free floating and no late rise after gate low
  AST_MAIN_FLOAT_LOW: assert property (s_main_float |-> !$past(main_out))
    else $error("main output floated while high");
  AST_MAIN_FLOAT_CAUSE: assert property (s_main_float |-> !$past(powerdown_or_refsel_pin, 2))
    else $error("main output floated without synced pin low");
  AST_TAP_AFTER_MAIN: assert property (s_tap_float |-> !main_out_oe)
    else $error("tap floated before main output");
  AST_TAP_FLOAT_LOW: assert property (s_tap_float |-> !$past(reference_tap_pin))
    else $error("tap floated while high");
  AST_TAP_NO_GATE: assert property (s_tap_float |-> !$past(powerdown_or_refsel_pin, 2))
    else $error("tap disabled without power-down");
  AST_OSC_LAST: assert property (s_osc_stop |-> !main_out_oe && !reference_tap_oe)
    else $error("oscillator stopped before outputs floated");
  AST_OSC_CAUSE: assert property (s_osc_stop |-> !$past(powerdown_or_refsel_pin, 2))
    else $error("oscillator stopped without pin low");
  AST_OFF_FLOATS: assert property (!osc_enable |-> !main_out_oe && !reference_tap_oe)
    else $error("output driven while powered down");
  AST_NO_RISE_GATED: assert property ($rose(main_out) |-> low_cnt_r < GRACE)
    else $error("main output rose long after gate low");
endmodule
bind ref_select_prescale_divider_ctrl ref_ctrl_checker #(.CFG_W(CFG_W), .SYNC_STAGES(SYNC_STAGES)) u_ref_ctrl_checker (
  .clk(clk), .rst_n(rst_n), .internal_osc(internal_osc), .ext_ref_pin(ext_ref_pin),
  .output_gate_pin(output_gate_pin), .powerdown_or_refsel_pin(powerdown_or_refsel_pin),
  .program_mode(program_mode), .prog_data_in(prog_data_in), .prog_strobe(prog_strobe), .prog_cmd(prog_cmd),
  .main_out(main_out), .main_out_oe(main_out_oe), .reference_tap_pin(reference_tap_pin),
  .reference_tap_oe(reference_tap_oe), .osc_enable(osc_enable));
`default_nettype wire

/* File: clk_sink.sv */
// board-side model consuming the generated clock outputs
// assumes the bench clock; released lines show a changing pattern
`timescale 1ns/100ps
`default_nettype none
module clk_sink (
  input wire logic clk,
  input wire logic main_out,
  input wire logic main_out_oe,
  input wire logic reference_tap_pin,
  input wire logic reference_tap_oe,
  output logic [15:0] main_period,
  output logic [15:0] tap_period
);
  logic pat_r = 1'b0;
  logic mprev_r, tprev_r, main_wire, tap_wire;
  logic [15:0] mcnt_r, tcnt_r;
  // released lines toggle every cycle instead of holding
  assign main_wire = main_out_oe ? main_out : pat_r;
  assign tap_wire = reference_tap_oe ? reference_tap_pin : ~pat_r;
  // rising-edge to rising-edge period of each driven line
  always @(posedge clk) begin
    pat_r <= ~pat_r;
    mprev_r <= main_wire;
    tprev_r <= tap_wire;
    mcnt_r <= (main_wire && !mprev_r) ? 16'h0001 : mcnt_r + 16'h0001;
    tcnt_r <= (tap_wire && !tprev_r) ? 16'h0001 : tcnt_r + 16'h0001;
    if (main_wire && !mprev_r && main_out_oe) main_period <= mcnt_r;
    if (tap_wire && !tprev_r && reference_tap_oe) tap_period <= tcnt_r;
  end
endmodule
`default_nettype wire

/* File: test_ref_select_prescale_divider_ctrl.sv */
// self-checking bench: programs mode and divider words, measures outputs
// assumes reference clocks of 8 and 12 system cycles
`timescale 1ns/100ps
`default_nettype none
`include "clkgen_regs.svh"
module test_ref_select_prescale_divider_ctrl;
  logic clk = 1'b0, rst_n = 1'b0, internal_osc = 1'b0, ext_ref_pin = 1'b0, output_gate_pin = 1'b1;
  logic powerdown_or_refsel_pin = 1'b1, program_mode = 1'b1, prog_data_in = 1'b0, prog_strobe = 1'b0;
  logic [`CMD_W-1:0] prog_cmd = 2'h0;
  wire logic main_out, main_out_oe, reference_tap_pin, reference_tap_oe, osc_enable;
  wire logic [15:0] main_period, tap_period;
  int miscompares = 0, cmp_count = 0, cycles = 0, n;
  logic [8:0] md [10] = '{9'h014, 9'h010, 9'h018, 9'h01e, 9'h011, 9'h005, 9'h004, 9'h014, 9'h034, 9'h014};
  logic [8:0] dv [10] = '{9'h001, 9'h001, 9'h001, 9'h001, 9'h001, 9'h001, 9'h001, 9'h000, 9'h001, 9'h1ff};
  logic [15:0] em [10] = '{16'd24, 16'd96, 16'd48, 16'd8, 16'd36, 16'd24, 16'd36, 16'd16, 16'd24, 16'd4104};
  logic [15:0] et [10] = '{16'd8, 16'd0, 16'd0, 16'd8, 16'd12, 16'd8, 16'd12, 16'd8, 16'd0, 16'd8};
  logic pn [10] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
  ref_select_prescale_divider_ctrl u_ref_select_prescale_divider_ctrl (
    .clk(clk), .rst_n(rst_n), .internal_osc(internal_osc), .ext_ref_pin(ext_ref_pin),
    .output_gate_pin(output_gate_pin), .powerdown_or_refsel_pin(powerdown_or_refsel_pin),
    .program_mode(program_mode), .prog_data_in(prog_data_in), .prog_strobe(prog_strobe), .prog_cmd(prog_cmd),
    .main_out(main_out), .main_out_oe(main_out_oe), .reference_tap_pin(reference_tap_pin),
    .reference_tap_oe(reference_tap_oe), .osc_enable(osc_enable));
  clk_sink u_clk_sink (
    .clk(clk), .main_out(main_out), .main_out_oe(main_out_oe), .reference_tap_pin(reference_tap_pin),
    .reference_tap_oe(reference_tap_oe), .main_period(main_period), .tap_period(tap_period));
  // system clock and the two free-running references
  initial begin
    forever #2 clk = ~clk;
  end
  initial begin
    #3;
    forever #16 internal_osc = ~internal_osc;
  end
  initial begin
    #3;
    forever #24 ext_ref_pin = ~ext_ref_pin;
  end
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic step(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic check(logic [15:0] got, logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %0d expected %0d", $time, got, exp);
    end
  endtask
  // one serial command, strobe held four cycles each way
  task automatic strobe(clkgen_pkg::cmd_e cmd, logic b);
    prog_cmd = cmd;
    prog_data_in = b;
    step(1);
    prog_strobe = 1'b1;
    step(4);
    prog_strobe = 1'b0;
    step(4);
  endtask
  // program both words msb first, then restart in operating mode
  task automatic load(logic [8:0] mode, logic [8:0] div, logic pin);
    rst_n = 1'b0;
    program_mode = 1'b1;
    step(10);
    rst_n = 1'b1;
    step(4);
    for (int i = 8; i >= 0; i--) strobe(clkgen_pkg::CMD_NONE, mode[i]);
    strobe(clkgen_pkg::CMD_LOAD_MODE, 1'b0);
    for (int i = 8; i >= 0; i--) strobe(clkgen_pkg::CMD_NONE, div[i]);
    strobe(clkgen_pkg::CMD_LOAD_DIV, 1'b0);
    strobe(clkgen_pkg::CMD_WRITE, 1'b0);
    powerdown_or_refsel_pin = pin;
    rst_n = 1'b0;
    program_mode = 1'b0;
    step(10);
    rst_n = 1'b1;
  endtask
  task automatic close_out();
    if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 10; i++) begin
      load(md[i], dv[i], pn[i]);
      step(2 * em[i] + 60);
      check(main_period, em[i]);
      if (et[i] != 16'd0) check(tap_period, et[i]);
      if (md[i][5]) check({15'h0, reference_tap_oe}, 16'h0000);
    end
    // gate low holds output low while tap keeps running
    load(9'h014, 9'h001, 1'b1);
    step(100);
    output_gate_pin = 1'b0;
    step(40);
    n = 0;
    repeat (60) begin
      step(1);
      if (main_out !== 1'b0) n++;
    end
    check(n[15:0], 16'h0000);
    check(tap_period, 16'd8);
    output_gate_pin = 1'b1;
    n = 0;
    while (main_out !== 1'b1 && n < 40) begin
      step(1);
      n++;
    end
    check({15'h0, n <= 19}, 16'h0001);
    // power-down sequence and recovery
    powerdown_or_refsel_pin = 1'b0;
    step(120);
    check({13'h0, main_out_oe, reference_tap_oe, osc_enable}, 16'h0000);
    powerdown_or_refsel_pin = 1'b1;
    step(120);
    check({13'h0, main_out_oe, reference_tap_oe, osc_enable}, 16'h0007);
    // strobes outside programming mode leave staged words and store alone
    for (int i = 0; i < 9; i++) strobe(clkgen_pkg::CMD_NONE, 1'b1);
    strobe(clkgen_pkg::CMD_LOAD_DIV, 1'b0);
    strobe(clkgen_pkg::CMD_WRITE, 1'b0);
    rst_n = 1'b0;
    step(10);
    rst_n = 1'b1;
    step(120);
    check(main_period, 16'd24);
    close_out();
  end
endmodule
`default_nettype wire
